// file: pdmc_pkg.sv
// constants, types and register map of the power-down mode controller
package pdmc_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam int          ADDR_DEC_W     = 12;
   localparam logic [11:0] CTRL_STAT_OFF  = 12'h000;
   localparam logic [11:0] PD_STATUS_OFF  = 12'h004;

   // ****************************************************************
   // power-down field layout and codes
   // ****************************************************************
   localparam int         PDF_LSB         = 10;
   localparam int         PDF_MSB         = 15;
   localparam int         PDF_W           = 6;
   localparam logic [5:0] PDF_RESET       = 6'h00;
   localparam logic [5:0] PDF_NONE        = 6'h00;
   localparam logic [5:0] PDF_LS_ENA      = 6'h09;
   localparam logic [5:0] PDF_LS_ANY      = 6'h11;
   localparam logic [5:0] PDF_PLL_OUT     = 6'h1A;
   localparam logic [5:0] PDF_PLL_IN      = 6'h1C;

   // status register fields
   localparam int ST_STATE_LSB = 0;
   localparam int ST_MASK_BIT  = 4;
   localparam int ST_LOCK_BIT  = 5;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int         CLK_MHZ        = 50;
   localparam int         ARM_CYCLES     = 8;
   localparam logic [3:0] ARM_LOAD       = 4'(ARM_CYCLES - 1);
   localparam int         LOCK_TIME_US   = 75;
   localparam int         LOCK_CYC       = LOCK_TIME_US * CLK_MHZ;
   localparam logic [11:0] LOCK_LAST     = 12'(LOCK_CYC - 1);

   // ahb encodings
   localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
   localparam logic       HRESP_OKAY     = 1'h0;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [2:0] {
      PD_RUN,
      PD_ARMING,
      PD_SLEEP,
      PD_HALT_OUT,
      PD_STOP_IN
   } pdmc_state_e;

   typedef struct packed {
      logic cpu_clk_en;
      logic xfer_clk_en;
      logic pll_out_en;
      logic inclk_en;
      logic io_freeze;
   } pdmc_clk_ctl_s;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [11:0] addr;
   } pdmc_dph_s;

endpackage

// file: pdmc_sync.sv
// two-flop synchronisers for inputs arriving from outside the clock domain
`timescale 1ns/1ps

module pdmc_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   // ****************************************************************
   // one chain per bit
   // ****************************************************************
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= async_in[i];
               sync_q <= meta_q;
            end
         end
         assign sync_out[i] = sync_q;
      end
   endgenerate

endmodule

// file: pdmc_top.sv
// power-down mode controller with ahb-lite register access
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps

// How it works
// - the mode and its wake-up method come from bits 15 to 10 of control_status.
// - light sleep starts eight cycles after the field write is committed.
// - under code 010001 a non-enabled interrupt ends light sleep and resumes at the stored pc.
// - an enabled interrupt ends light sleep, runs its handler, then resumes.
// - the two pll-halting modes end only through device reset.
// - code 001001 wakes on enabled interrupts, 010001 on any interrupt.
// - light sleep stops the cpu clock but keeps the interrupt logic running.
// - the transfer engine clock keeps running in light sleep.
// - code 011010 halts the pll output and with it the whole chip.
// - code 011100 stops the pll input, and the pll re-locks after reset.
// - pll-halting modes keep all state and freeze functional outputs.
// - only the input clock pin is gated, other input clocks never.
// - an attached emulator masks power-down until its reset or removal.
// - in pll-halting modes emulation commands spin idle and pc writes fail.
module pdmc_top
   import pdmc_pkg::*;
(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic               hreadyout,
   output logic               hresp,
   output logic [31:0]        hrdata,
   input  wire logic          irq_enabled,
   input  wire logic          irq_nonenabled,
   input  wire logic [31:0]   cpu_pc,
   input  wire logic          emu_attached,
   input  wire logic          emu_reset_n,
   input  wire logic          emu_exec_cmd,
   output pdmc_clk_ctl_s      clk_ctl,
   output logic               sleep_active,
   output logic               wake_isr,
   output logic               wake_resume,
   output logic [31:0]        resume_pc,
   output logic               emu_spin_idle,
   output logic               pc_write_ok,
   output logic               pll_locked
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      pdmc_state_e  state;
      logic [3:0]   arm_cnt;
      logic [11:0]  lock_cnt;
      logic         locked;
      logic [5:0]   field;
      logic         mask;
      logic         attach_prev;
      pdmc_dph_s    dph;
      logic [31:0]  rdata;
      logic [31:0]  resume_pc;
      logic         wake_isr;
      logic         wake_resume;
      logic         spin;
   } pdmc_regs_s;

   localparam pdmc_regs_s REGS_RESET = '{
      state:       PD_RUN,
      arm_cnt:     4'h0,
      lock_cnt:    12'h000,
      locked:      1'b0,
      field:       PDF_RESET,
      mask:        1'b0,
      attach_prev: 1'b0,
      dph:         '0,
      rdata:       32'h0000_0000,
      resume_pc:   32'h0000_0000,
      wake_isr:    1'b0,
      wake_resume: 1'b0,
      spin:        1'b0
   };

   pdmc_regs_s   st_q;
   pdmc_regs_s   st_d;
   logic [1:0]   emu_s;
   logic         attach_s;
   logic         emu_rst_n_s;
   logic         addr_phase;
   logic         csr_commit;
   logic [5:0]   wr_field;
   logic         halted;
   logic [31:0]  status_word;
   logic [31:0]  csr_word;

   // ****************************************************************
   // emulator pins
   // ****************************************************************
   pdmc_sync #(
      .WIDTH (2)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({emu_reset_n, emu_attached}),
      .sync_out (emu_s)
   );

   assign attach_s    = emu_s[0];
   assign emu_rst_n_s = emu_s[1];

   // ****************************************************************
   // bus decode
   // ****************************************************************
   assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
   assign wr_field   = hwdata[PDF_MSB:PDF_LSB];
   assign csr_commit = st_q.dph.valid && st_q.dph.write &&
                       (st_q.dph.addr == CTRL_STAT_OFF);
   assign halted     = (st_q.state == PD_HALT_OUT) ||
                       (st_q.state == PD_STOP_IN);

   always_comb begin
      csr_word = 32'h0000_0000;
      csr_word[PDF_MSB:PDF_LSB] = st_q.field;
      status_word = 32'h0000_0000;
      status_word[ST_STATE_LSB +: 3] = st_q.state;
      status_word[ST_MASK_BIT] = st_q.mask;
      status_word[ST_LOCK_BIT] = st_q.locked;
   end

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_d             = st_q;
      st_d.wake_isr    = 1'b0;
      st_d.wake_resume = 1'b0;
      st_d.attach_prev = attach_s;

      // pll lock timer, restarted by every device reset
      if (!st_q.locked) begin
         if (st_q.lock_cnt == LOCK_LAST) begin
            st_d.locked = 1'b1;
         end else begin
            st_d.lock_cnt = st_q.lock_cnt + 12'h001;
         end
      end

      // emulator mask: set on attach, cleared by its reset or removal
      if (!attach_s || !emu_rst_n_s) begin
         st_d.mask = 1'b0;
      end else if (attach_s && !st_q.attach_prev) begin
         st_d.mask = 1'b1;
      end

      // register bus
      st_d.dph.valid = addr_phase;
      st_d.dph.write = hwrite;
      st_d.dph.addr  = haddr[ADDR_DEC_W-1:0];
      if (addr_phase && !hwrite) begin
         case (haddr[ADDR_DEC_W-1:0])
            CTRL_STAT_OFF: st_d.rdata = csr_word;
            PD_STATUS_OFF: st_d.rdata = status_word;
            default:       st_d.rdata = 32'h0000_0000;
         endcase
      end
      if (csr_commit) begin
         st_d.field = wr_field;
      end

      // emulation commands in halted modes
      st_d.spin = halted && emu_exec_cmd;

      case (st_q.state)
         PD_RUN: begin
            if (csr_commit && !st_q.mask) begin
               case (wr_field)
                  PDF_LS_ENA, PDF_LS_ANY: begin
                     st_d.state   = PD_ARMING;
                     st_d.arm_cnt = ARM_LOAD;
                  end
                  PDF_PLL_OUT: st_d.state = PD_HALT_OUT;
                  PDF_PLL_IN:  st_d.state = PD_STOP_IN;
                  default:     st_d.state = PD_RUN;
               endcase
            end
         end
         PD_ARMING: begin
            if (st_q.mask) begin
               st_d.state = PD_RUN;
            end else if (st_q.arm_cnt == 4'h0) begin
               st_d.state     = PD_SLEEP;
               st_d.resume_pc = cpu_pc;
            end else begin
               st_d.arm_cnt = st_q.arm_cnt - 4'h1;
            end
         end
         PD_SLEEP: begin
            if (irq_enabled) begin
               st_d.state    = PD_RUN;
               st_d.wake_isr = 1'b1;
            end else if (irq_nonenabled &&
                         st_q.field == PDF_LS_ANY) begin
               st_d.state       = PD_RUN;
               st_d.wake_resume = 1'b1;
            end else if (st_q.mask) begin
               st_d.state       = PD_RUN;
               st_d.wake_resume = 1'b1;
            end
         end
         PD_HALT_OUT: st_d.state = PD_HALT_OUT;
         PD_STOP_IN:  st_d.state = PD_STOP_IN;
         default:     st_d.state = PD_RUN;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= REGS_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign hreadyout     = 1'b1;
   assign hresp         = HRESP_OKAY;
   assign hrdata        = st_q.rdata;
   assign sleep_active  = (st_q.state == PD_SLEEP);
   assign wake_isr      = st_q.wake_isr;
   assign wake_resume   = st_q.wake_resume;
   assign resume_pc     = st_q.resume_pc;
   assign emu_spin_idle = st_q.spin;
   assign pc_write_ok   = !halted;
   assign pll_locked    = st_q.locked;

   // interrupt logic is outside this gate and keeps its clock
   assign clk_ctl.cpu_clk_en  = (st_q.state != PD_SLEEP) && !halted;
   assign clk_ctl.xfer_clk_en = !halted;
   assign clk_ctl.pll_out_en  = !halted;
   // of the input clocks only the pin clock has a gate; other input clocks bypass this block
   assign clk_ctl.inclk_en    = (st_q.state != PD_STOP_IN);
   assign clk_ctl.io_freeze   = halted;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_sleep_req;
      csr_commit && (st_q.state == PD_RUN) && !st_q.mask &&
      (wr_field == PDF_LS_ENA || wr_field == PDF_LS_ANY);
   endsequence

   sequence s_arm_wait;
      (st_q.state == PD_ARMING) [*8];
   endsequence

   a_field_store: assert property (
      csr_commit |=> st_q.field == $past(wr_field))
      else $error("power-down field not stored");

   a_sleep_delay: assert property (
      s_sleep_req |-> ##1 s_arm_wait ##1 sleep_active)
      else $error("light sleep not entered after eight cycles");

   a_wake_isr: assert property (
      sleep_active && irq_enabled |=> wake_isr && !sleep_active)
      else $error("enabled interrupt did not wake with handler");

   a_wake_plain: assert property (
      sleep_active && irq_nonenabled && !irq_enabled && !st_q.mask &&
      st_q.field == PDF_LS_ANY |=> wake_resume && !wake_isr)
      else $error("non-enabled interrupt did not resume");

   a_enabled_only: assert property (
      sleep_active && irq_nonenabled && !irq_enabled && !st_q.mask &&
      st_q.field == PDF_LS_ENA |=> sleep_active)
      else $error("non-enabled interrupt woke enabled-only sleep");

   a_resume_hold: assert property (
      sleep_active |=> $stable(resume_pc))
      else $error("resume point changed during sleep");

   a_halt_sticky: assert property (
      halted |=> halted && $stable(st_q.state))
      else $error("pll-halting mode left without reset");

   a_sleep_gate: assert property (
      sleep_active |-> !clk_ctl.cpu_clk_en && clk_ctl.xfer_clk_en)
      else $error("sleep clock gating wrong");

   a_halt_gate: assert property (
      halted |-> !clk_ctl.pll_out_en && clk_ctl.io_freeze &&
      !clk_ctl.cpu_clk_en)
      else $error("halt gating wrong");

   a_inclk_gate: assert property (
      (st_q.state != PD_STOP_IN) |-> clk_ctl.inclk_en)
      else $error("input clock gated outside input stop");

   a_emu_mask: assert property (
      csr_commit && st_q.mask && st_q.state == PD_RUN |=> !halted &&
      st_q.state == PD_RUN)
      else $error("power-down entered while emulator attached");

   a_emu_spin: assert property (
      halted && emu_exec_cmd |=> emu_spin_idle && !pc_write_ok)
      else $error("emulation command not held idle");

   a_reserved: assert property (
      csr_commit && st_q.state == PD_RUN && wr_field != PDF_LS_ENA &&
      wr_field != PDF_LS_ANY && wr_field != PDF_PLL_OUT &&
      wr_field != PDF_PLL_IN |=> st_q.state == PD_RUN)
      else $error("reserved code entered a mode");

   a_mask_wake: assert property (
      sleep_active && st_q.mask && !irq_enabled |=> wake_resume && !sleep_active)
      else $error("emulator mask did not end light sleep");

   a_halt_quiet: assert property (
      halted |-> !wake_isr && !wake_resume)
      else $error("wake pulse while pll is halted");

   a_wake_pulse: assert property (
      wake_isr || wake_resume |=> !wake_isr && !wake_resume)
      else $error("wake pulse longer than one cycle");

   a_lock_hold: assert property (
      pll_locked |=> pll_locked)
      else $error("pll lock dropped without reset");

   a_spin_clear: assert property (
      !halted |=> !emu_spin_idle)
      else $error("emulation command held idle while running");

endmodule

// file: pdmc_cpu_model.sv
// cpu-side model: program counter and pending interrupt lines
`timescale 1ns/1ps

module pdmc_cpu_model
   import pdmc_pkg::*;
(
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire pdmc_clk_ctl_s clk_ctl,
   input  wire logic          wake_isr,
   input  wire logic          wake_resume,
   input  wire logic [31:0]   resume_pc,
   input  wire logic          raise_en,
   input  wire logic          raise_ne,
   output logic               irq_enabled,
   output logic               irq_nonenabled,
   output logic [31:0]        cpu_pc
);
   // ****************************************************************
   // pending interrupts and program flow
   // ****************************************************************
   logic [2:0] isr_cnt_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_enabled    <= 1'h0;
         irq_nonenabled <= 1'h0;
         cpu_pc         <= 32'h0000_0100;
         isr_cnt_q      <= 3'h0;
      end else begin
         if (raise_en) begin
            irq_enabled <= 1'h1;
         end
         if (raise_ne) begin
            irq_nonenabled <= 1'h1;
         end
         // a wake acknowledges whatever is pending
         if (wake_isr || wake_resume) begin
            irq_enabled    <= 1'h0;
            irq_nonenabled <= 1'h0;
         end
         if (wake_isr) begin
            cpu_pc    <= 32'h0000_0F00;
            isr_cnt_q <= 3'h4;
         end else if (wake_resume) begin
            cpu_pc <= resume_pc;
         end else if (isr_cnt_q == 3'h1) begin
            cpu_pc    <= resume_pc;
            isr_cnt_q <= 3'h0;
         end else if (clk_ctl.cpu_clk_en) begin
            cpu_pc <= cpu_pc + 32'h4;
            if (isr_cnt_q != 3'h0) begin
               isr_cnt_q <= isr_cnt_q - 3'h1;
            end
         end
      end
   end
endmodule

// file: pdmc_top_test.sv
// self-checking bench of the power-down mode controller
`timescale 1ns/1ps

module pdmc_top_test;
   import pdmc_pkg::*;

   typedef struct packed {
      logic [5:0] code;
      logic [2:0] st;
   } pdmc_row_s;

   logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0]   haddr, hwdata, hrdata, cpu_pc, resume_pc, rd;
   logic [1:0]    htrans;
   logic [2:0]    hsize;
   logic          irq_enabled, irq_nonenabled, raise_en, raise_ne;
   logic          emu_attached, emu_reset_n, emu_exec_cmd, emu_spin_idle;
   logic          sleep_active, wake_isr, wake_resume;
   logic          pc_write_ok, pll_locked;
   pdmc_clk_ctl_s clk_ctl;
   int            errors, cmp_count, n;
   pdmc_row_s     rows [9] = '{
      '{PDF_NONE, 3'h0}, '{PDF_LS_ENA, 3'h2}, '{PDF_LS_ANY, 3'h2},
      '{PDF_PLL_OUT, 3'h3}, '{PDF_PLL_IN, 3'h4}, '{6'h1F, 3'h0},
      '{6'h0A, 3'h0}, '{6'h01, 3'h0}, '{6'h12, 3'h0}};

   assign hready = hreadyout;

   pdmc_top uut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .irq_enabled, .irq_nonenabled,
      .cpu_pc, .emu_attached, .emu_reset_n, .emu_exec_cmd, .clk_ctl,
      .sleep_active, .wake_isr, .wake_resume, .resume_pc, .emu_spin_idle,
      .pc_write_ok, .pll_locked
   );

   pdmc_cpu_model cpu (
      .hclk, .hresetn, .clk_ctl, .wake_isr, .wake_resume, .resume_pc,
      .raise_en, .raise_ne, .irq_enabled, .irq_nonenabled, .cpu_pc
   );

   initial begin
      hclk = 1'h0;
      forever #10 hclk = ~hclk;
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic check1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask

   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hready !== 1'b1 && k < 16);
      if (hready !== 1'b1) begin
         errors++;
         report_and_stop();
      end
   endtask

   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'h1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      haddr  <= {20'h0, a};
      wait_rdy();
      hsel   <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   // whole field in one write, reserved top bit always zero
   task automatic wr_field(input logic [5:0] code);
      bus(1'h1, CTRL_STAT_OFF, {16'h0, 1'h0, code[4:0], 10'h0});
   endtask

   task automatic pulse_irq(input logic en, input logic ne);
      @(posedge hclk);
      raise_en <= en;
      raise_ne <= ne;
      @(posedge hclk);
      raise_en <= 1'h0;
      raise_ne <= 1'h0;
      @(posedge hclk);
      #1;
   endtask

   task automatic do_reset;
      @(posedge hclk);
      hresetn <= 1'h0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
   endtask

   // ****************************************************************
   // sequence
   // ****************************************************************
   initial begin
      {hsel, hwrite, emu_attached, emu_exec_cmd, raise_en, raise_ne} = '0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      hresetn = 1'h0;
      emu_reset_n = 1'h1;
      errors = 0;
      cmp_count = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      #1;
      check({27'h0, clk_ctl}, 32'h0000_001E);
      check1(pc_write_ok, 1'h1);
      n = 0;
      while (pll_locked !== 1'b1 && n < 5000) begin
         @(posedge hclk);
         #1;
         n++;
      end
      check1(n >= 3749 && n <= 3751, 1'h1);
      bus(1'h0, 12'h008, 32'h0);
      check(rd, 32'h0);
      check1(hresp, HRESP_OKAY);
      foreach (rows[i]) begin
         do_reset();
         wr_field(rows[i].code);
         repeat (10) @(posedge hclk);
         bus(1'h0, PD_STATUS_OFF, 32'h0);
         check({29'h0, rd[2:0]}, {29'h0, rows[i].st});
         bus(1'h0, CTRL_STAT_OFF, 32'h0);
         check(rd, {16'h0, rows[i].code, 10'h0});
         #1;
         check1(sleep_active, rows[i].st == 3'h2);
         check1(clk_ctl.cpu_clk_en, rows[i].st == 3'h0);
         check1(clk_ctl.inclk_en, rows[i].st != 3'h4);
         check1(clk_ctl.io_freeze, rows[i].st > 3'h2);
         check1(pc_write_ok, rows[i].st < 3'h3);
         if (rows[i].st == 3'h2) begin
            check1(clk_ctl.xfer_clk_en, 1'h1);
         end
         if (rows[i].st == 3'h3) begin
            check1(clk_ctl.pll_out_en, 1'h0);
         end
         if (rows[i].st > 3'h2) begin
            @(posedge hclk);
            emu_exec_cmd <= 1'h1;
            pulse_irq(1'h1, 1'h1);
            check1(emu_spin_idle, 1'h1);
            check1(wake_isr | wake_resume, 1'h0);
            @(posedge hclk);
            emu_exec_cmd <= 1'h0;
            bus(1'h0, PD_STATUS_OFF, 32'h0);
            check({29'h0, rd[2:0]}, {29'h0, rows[i].st});
         end
      end
      do_reset();
      wr_field(PDF_LS_ENA);
      repeat (7) @(posedge hclk);
      #1;
      check1(sleep_active, 1'h0);
      @(posedge hclk);
      #1;
      check1(sleep_active, 1'h1);
      pulse_irq(1'h0, 1'h1);
      check1(sleep_active & ~wake_resume, 1'h1);
      check1(resume_pc === cpu_pc || resume_pc === cpu_pc - 32'h4, 1'h1);
      pulse_irq(1'h1, 1'h0);
      check1(wake_isr, 1'h1);
      check1(sleep_active | wake_resume, 1'h0);
      @(posedge hclk);
      #1;
      check1(wake_isr, 1'h0);
      wr_field(PDF_LS_ANY);
      repeat (10) @(posedge hclk);
      pulse_irq(1'h0, 1'h1);
      check1(wake_resume & ~wake_isr, 1'h1);
      wr_field(PDF_LS_ANY);
      repeat (10) @(posedge hclk);
      pulse_irq(1'h1, 1'h1);
      check1(wake_isr & ~wake_resume, 1'h1);
      @(posedge hclk);
      emu_attached <= 1'h1;
      repeat (5) @(posedge hclk);
      bus(1'h0, PD_STATUS_OFF, 32'h0);
      check1(rd[4], 1'h1);
      wr_field(PDF_LS_ANY);
      repeat (10) @(posedge hclk);
      #1;
      check1(sleep_active, 1'h0);
      @(posedge hclk);
      emu_reset_n <= 1'h0;
      repeat (5) @(posedge hclk);
      emu_reset_n <= 1'h1;
      bus(1'h0, PD_STATUS_OFF, 32'h0);
      check1(rd[4], 1'h0);
      wr_field(PDF_LS_ANY);
      repeat (10) @(posedge hclk);
      #1;
      check1(sleep_active, 1'h1);
      @(posedge hclk);
      emu_attached <= 1'h0;
      repeat (4) @(posedge hclk);
      emu_attached <= 1'h1;
      repeat (4) @(posedge hclk);
      #1;
      check1(wake_resume & ~sleep_active, 1'h1);
      report_and_stop();
   end
endmodule
